// >>> shared_ports_consts.vh
// Purpose: Constants for the shared-pin parallel port block.
// Assumes: 16-bit register address, 8-bit register data.
// Notes:   Definitions only, guarded against double inclusion.
`ifndef SHARED_PORTS_CONSTS_VH
`define SHARED_PORTS_CONSTS_VH

// Register addresses
`define PD_DATA_ADDR 16'h0003
`define PE_DATA_ADDR 16'h0008
`define PD_DIR_ADDR 16'h0007
`define PE_DIR_ADDR 16'h000C
`define PC_PUE_ADDR 16'h000B
`define PD_PUE_ADDR 16'h000D

// Port widths
`define PC_W 2
`define PD_W 7
`define PE_W 2

// Reset values
`define PD_DIR_RST 7'h00
`define PE_DIR_RST 2'h0
`define PC_PUE_RST 2'h0
`define PD_PUE_RST 7'h00
`define LATCH_PWRUP_D 7'h00
`define LATCH_PWRUP_E 2'h0
`define RDATA_IDLE 8'h00

// Port D pin positions
`define PD_SS_BIT 0
`define PD_MISO_BIT 1
`define PD_MOSI_BIT 2
`define PD_SCK_BIT 3
`define PD_T1C0_BIT 4
`define PD_T1C1_BIT 5
`define PD_T2C0_BIT 6

// Port E pin positions
`define PE_TX_BIT 0
`define PE_RX_BIT 1

`endif

// >>> pin_sync.v
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Pins are asynchronous to the bus clock.
// Notes:   A change is accepted once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter W = 1
) (
   input wire clk_in,
   input wire nrst_in,
   input wire ce_in,
   input wire [W-1:0] pin_in,
   output reg [W-1:0] level_out
);

   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;

   ////////////////////////////////////////////////////////////////////////
   // Stage one feeds only stage two; output moves on agreement
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
         level_out <= {W{1'b0}};
      end else if (ce_in) begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // Per bit: follow when both agree, else hold
         level_out <= (s2_r & s3_r) | (level_out & (s2_r | s3_r));
      end
   end

endmodule

`default_nettype wire

// >>> shared_pin_ports.v
// Purpose: Parallel I/O for ports C (pullups), D and E with
//          peripheral pin sharing (SPI, two timers, serial iface).
// Assumes: Single bus clock; peripherals on the same clock.
// Notes:   Pin outputs, enables and pullups are all registered.
//          Reads answer one cycle after the strobe.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "shared_ports_consts.vh"

module shared_pin_ports (
   input wire REF_CLK_IN,
   input wire NRST_IN,
   input wire CE_IN,
   // Register port
   input wire [15:0] ADDR_IN,
   input wire [7:0] WDATA_IN,
   input wire WR_IN,
   input wire RD_IN,
   output reg [7:0] RDATA_OUT,
   // Port C pullups, direction kept elsewhere
   input wire [`PC_W-1:0] PORT_C_DIRECTION_IN,
   output reg [`PC_W-1:0] PC_PULLUP_OUT,
   // Port D pins
   input wire [`PD_W-1:0] PD_PIN_IN,
   output reg [`PD_W-1:0] PD_PIN_OUT,
   output reg [`PD_W-1:0] PD_OE_N_OUT,
   output reg [`PD_W-1:0] PD_PULLUP_OUT,
   // Port E pins
   input wire [`PE_W-1:0] PE_PIN_IN,
   output reg [`PE_W-1:0] PE_PIN_OUT,
   output reg [`PE_W-1:0] PE_OE_N_OUT,
   // SPI side, bits 3..0 follow port D bits 3..0
   input wire SPI_ENABLE_IN,
   input wire SPI_MASTER_SELECT_IN,
   input wire [3:0] SPI_DATA_IN,
   input wire [3:0] SPI_DRIVE_IN,
   // Timer channel selects: bit 1 high select, bit 0 low select
   input wire [1:0] TIMER_ONE_CHANNEL_ZERO_SEL_IN,
   input wire [1:0] TIMER_ONE_CHANNEL_ONE_SEL_IN,
   input wire [1:0] TIMER_TWO_CHANNEL_ZERO_SEL_IN,
   // Timer pin data and drive, bits 2..0 follow port D bits 6..4
   input wire [2:0] TIMER_DATA_IN,
   input wire [2:0] TIMER_DRIVE_IN,
   // Serial interface side
   input wire SERIAL_IFACE_ENABLE_IN,
   input wire SERIAL_TX_DATA_IN
);

   ////////////////////////////////////////////////////////////////////////
   // Register storage

   // Data latches have no reset; power-up value keeps sim defined
   reg [`PD_W-1:0] port_d_data_latch_r = `LATCH_PWRUP_D;
   reg [`PE_W-1:0] port_e_data_latch_r = `LATCH_PWRUP_E;
   reg [`PD_W-1:0] port_d_direction_r;
   reg [`PE_W-1:0] port_e_direction_r;
   reg [`PC_W-1:0] port_c_pullup_enable_r;
   reg [`PD_W-1:0] port_d_pullup_enable_r;

   // Decoded strobes
   wire sel_pd_data;
   wire sel_pe_data;
   wire sel_pd_dir;
   wire sel_pe_dir;
   wire sel_pc_pue;
   wire sel_pd_pue;

   // Synchronised pin levels
   // Raw pads never reach the read mux
   wire [`PD_W-1:0] pd_level;
   wire [`PE_W-1:0] pe_level;

   // Pin ownership and next pin values
   reg [`PD_W-1:0] pd_owned;
   reg [`PD_W-1:0] pd_drive_nxt;
   reg [`PD_W-1:0] pd_data_nxt;
   reg [`PE_W-1:0] pe_owned;
   reg [`PE_W-1:0] pe_drive_nxt;
   reg [`PE_W-1:0] pe_data_nxt;
   reg [`PD_W-1:0] pd_pullup_nxt;
   reg [`PC_W-1:0] pc_pullup_nxt;
   reg [7:0] rdata_nxt;

   // Timer channel is active when either select bit is set
   wire t1c0_active;
   wire t1c1_active;
   wire t2c0_active;
   wire spi_pins_active;
   wire ss_active;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   // Full 16-bit compare, so no aliases in the map
   // Costs a wider comparator per register
   // Selects alone change nothing; strobes qualify them
   assign sel_pd_data = (ADDR_IN == `PD_DATA_ADDR);
   assign sel_pe_data = (ADDR_IN == `PE_DATA_ADDR);
   assign sel_pd_dir = (ADDR_IN == `PD_DIR_ADDR);
   assign sel_pe_dir = (ADDR_IN == `PE_DIR_ADDR);
   assign sel_pc_pue = (ADDR_IN == `PC_PUE_ADDR);
   assign sel_pd_pue = (ADDR_IN == `PD_PUE_ADDR);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Pads are asynchronous to the bus clock
   // Three flops guard against metastability
   // Read sees a settled pad four edges later
   // Pulses shorter than a cycle are filtered out
   pin_sync #(
      .W(`PD_W)
   ) u_sync_d (
      .clk_in(REF_CLK_IN),
      .nrst_in(NRST_IN),
      .ce_in(CE_IN),
      .pin_in(PD_PIN_IN),
      .level_out(pd_level)
   );

   pin_sync #(
      .W(`PE_W)
   ) u_sync_e (
      .clk_in(REF_CLK_IN),
      .nrst_in(NRST_IN),
      .ce_in(CE_IN),
      .pin_in(PE_PIN_IN),
      .level_out(pe_level)
   );

   ////////////////////////////////////////////////////////////////////////
   // Data latches: written regardless of direction, never reset
   // Old contents survive a reset
   // Writes to input pins land here only
   // Read value of an input pin stays the pad
   always @(posedge REF_CLK_IN) begin
      if (CE_IN && WR_IN) begin
         if (sel_pd_data) begin
            // Upper bit dropped on purpose
            port_d_data_latch_r <= WDATA_IN[`PD_W-1:0];
         end
         if (sel_pe_data) begin
            // Pre-loading here keeps a later output switch clean
            port_e_data_latch_r <= WDATA_IN[`PE_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Direction and pullup registers, cleared by reset
   // Inputs at reset, so nothing fights outside drivers
   // Pullups off until software asks
   // Upper write bits dropped on purpose
   always @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         port_d_direction_r <= `PD_DIR_RST;
         port_e_direction_r <= `PE_DIR_RST;
         port_c_pullup_enable_r <= `PC_PUE_RST;
         port_d_pullup_enable_r <= `PD_PUE_RST;
      end else if (CE_IN && WR_IN) begin
         if (sel_pd_dir) begin
            port_d_direction_r <= WDATA_IN[`PD_W-1:0];
         end
         if (sel_pe_dir) begin
            port_e_direction_r <= WDATA_IN[`PE_W-1:0];
         end
         if (sel_pc_pue) begin
            port_c_pullup_enable_r <= WDATA_IN[`PC_W-1:0];
         end
         if (sel_pd_pue) begin
            port_d_pullup_enable_r <= WDATA_IN[`PD_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Peripheral claim on shared pins
   // SPI and timer claims hand drive and data to the unit; serial pads get fixed drive
   // Direction register then only picks read source
   // Timer claims its pad in any non-port mode
   // Either edge/level select bit set means claimed
   assign t1c0_active = |TIMER_ONE_CHANNEL_ZERO_SEL_IN;
   assign t1c1_active = |TIMER_ONE_CHANNEL_ONE_SEL_IN;
   assign t2c0_active = |TIMER_TWO_CHANNEL_ZERO_SEL_IN;
   assign spi_pins_active = SPI_ENABLE_IN;
   // Slave select is free in master mode, where it is unused
   assign ss_active = SPI_ENABLE_IN & ~SPI_MASTER_SELECT_IN;

   ////////////////////////////////////////////////////////////////////////
   // Port D drive selection
   // Port view first, then each owner overrides
   // Registered before it reaches the pads
   always @* begin
      pd_owned = {`PD_W{1'b0}};
      pd_owned[`PD_SS_BIT] = ss_active;
      pd_owned[`PD_MISO_BIT] = spi_pins_active;
      pd_owned[`PD_MOSI_BIT] = spi_pins_active;
      pd_owned[`PD_SCK_BIT] = spi_pins_active;
      pd_owned[`PD_T1C0_BIT] = t1c0_active;
      pd_owned[`PD_T1C1_BIT] = t1c1_active;
      pd_owned[`PD_T2C0_BIT] = t2c0_active;
      // GPIO default: latch value, direction bit sets buffer
      pd_drive_nxt = port_d_direction_r;
      pd_data_nxt = port_d_data_latch_r;
      // Owned SPI pins: peripheral sets direction, not the register
      if (pd_owned[`PD_SS_BIT]) begin
         pd_drive_nxt[`PD_SS_BIT] = SPI_DRIVE_IN[0];
         pd_data_nxt[`PD_SS_BIT] = SPI_DATA_IN[0];
      end
      if (pd_owned[`PD_MISO_BIT]) begin
         pd_drive_nxt[`PD_MISO_BIT] = SPI_DRIVE_IN[1];
         pd_data_nxt[`PD_MISO_BIT] = SPI_DATA_IN[1];
      end
      if (pd_owned[`PD_MOSI_BIT]) begin
         pd_drive_nxt[`PD_MOSI_BIT] = SPI_DRIVE_IN[2];
         pd_data_nxt[`PD_MOSI_BIT] = SPI_DATA_IN[2];
      end
      if (pd_owned[`PD_SCK_BIT]) begin
         pd_drive_nxt[`PD_SCK_BIT] = SPI_DRIVE_IN[3];
         pd_data_nxt[`PD_SCK_BIT] = SPI_DATA_IN[3];
      end
      // Timer channels drive per their own capture/compare mode
      // Capture leaves drive low, compare sets it
      if (pd_owned[`PD_T1C0_BIT]) begin
         pd_drive_nxt[`PD_T1C0_BIT] = TIMER_DRIVE_IN[0];
         pd_data_nxt[`PD_T1C0_BIT] = TIMER_DATA_IN[0];
      end
      if (pd_owned[`PD_T1C1_BIT]) begin
         pd_drive_nxt[`PD_T1C1_BIT] = TIMER_DRIVE_IN[1];
         pd_data_nxt[`PD_T1C1_BIT] = TIMER_DATA_IN[1];
      end
      if (pd_owned[`PD_T2C0_BIT]) begin
         pd_drive_nxt[`PD_T2C0_BIT] = TIMER_DRIVE_IN[2];
         pd_data_nxt[`PD_T2C0_BIT] = TIMER_DATA_IN[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port E drive selection
   // One enable claims both serial pads
   // Receive forced to input: no fight with far end
   // Stray latch value cannot reach that pad while the interface is enabled
   always @* begin
      pe_owned = {`PE_W{1'b0}};
      pe_owned[`PE_RX_BIT] = SERIAL_IFACE_ENABLE_IN;
      pe_owned[`PE_TX_BIT] = SERIAL_IFACE_ENABLE_IN;
      pe_drive_nxt = port_e_direction_r;
      pe_data_nxt = port_e_data_latch_r;
      // Receive pin is a pure input while the interface owns it
      if (pe_owned[`PE_RX_BIT]) begin
         pe_drive_nxt[`PE_RX_BIT] = 1'b0;
         pe_data_nxt[`PE_RX_BIT] = 1'b0;
      end
      // Transmit pin always drives while owned
      if (pe_owned[`PE_TX_BIT]) begin
         pe_drive_nxt[`PE_TX_BIT] = 1'b1;
         pe_data_nxt[`PE_TX_BIT] = SERIAL_TX_DATA_IN;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pullups: only on undriven pins, dropped at once on output
   // Effective drive used, peripherals included
   // A driven pad never sinks pullup current
   // Limitation: port C sees only its direction
   always @* begin
      pd_pullup_nxt = port_d_pullup_enable_r & ~pd_drive_nxt;
      // Port C direction lives outside; gate it here all the same
      pc_pullup_nxt = port_c_pullup_enable_r & ~PORT_C_DIRECTION_IN;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux: direction register always picks latch or pin
   // Unmapped addresses and upper bits read zero
   // Only a read strobe opens the mux
   // Data fall back to zero after the read cycle
   always @* begin
      rdata_nxt = `RDATA_IDLE;
      if (RD_IN) begin
         if (sel_pd_data) begin
            // Pin reads ignore any ownership by a peripheral
            rdata_nxt[`PD_W-1:0] = (port_d_direction_r & port_d_data_latch_r)
               | (~port_d_direction_r & pd_level);
         end else if (sel_pe_data) begin
            rdata_nxt[`PE_W-1:0] = (port_e_direction_r & port_e_data_latch_r)
               | (~port_e_direction_r & pe_level);
         end else if (sel_pd_dir) begin
            rdata_nxt[`PD_W-1:0] = port_d_direction_r;
         end else if (sel_pe_dir) begin
            rdata_nxt[`PE_W-1:0] = port_e_direction_r;
         end else if (sel_pc_pue) begin
            rdata_nxt[`PC_W-1:0] = port_c_pullup_enable_r;
         end else if (sel_pd_pue) begin
            rdata_nxt[`PD_W-1:0] = port_d_pullup_enable_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   // One cycle of pin lag is traded for glitch-free, flop-driven pads
   // Reset releases every pad and drops pullups
   // Clock enable low holds every output
   always @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         RDATA_OUT <= `RDATA_IDLE;
         PD_PIN_OUT <= {`PD_W{1'b0}};
         PD_OE_N_OUT <= {`PD_W{1'b1}};
         PD_PULLUP_OUT <= {`PD_W{1'b0}};
         PE_PIN_OUT <= {`PE_W{1'b0}};
         PE_OE_N_OUT <= {`PE_W{1'b1}};
         PC_PULLUP_OUT <= {`PC_W{1'b0}};
      end else if (CE_IN) begin
         // Read data stand only in the cycle after the strobe
         RDATA_OUT <= rdata_nxt;
         PD_PIN_OUT <= pd_data_nxt;
         PD_OE_N_OUT <= ~pd_drive_nxt;
         PD_PULLUP_OUT <= pd_pullup_nxt;
         PE_PIN_OUT <= pe_data_nxt;
         PE_OE_N_OUT <= ~pe_drive_nxt;
         PC_PULLUP_OUT <= pc_pullup_nxt;
      end
   end

endmodule

`default_nettype wire

// >>> shared_pin_ports_monitor.sv
// Purpose: Port-level checks of the shared-pin port block.
// Assumes: CE_IN stays high while checked behaviour runs.
// Notes: Bound onto every instance of the block.
`timescale 1ns/1ps
`default_nettype none

module shared_pin_ports_monitor (
   input wire logic REF_CLK_IN,
   input wire logic NRST_IN,
   input wire logic CE_IN,
   input wire logic [1:0] PORT_C_DIRECTION_IN,
   input wire logic [1:0] PC_PULLUP_OUT,
   input wire logic [6:0] PD_OE_N_OUT,
   input wire logic [6:0] PD_PULLUP_OUT,
   input wire logic [1:0] PE_PIN_OUT,
   input wire logic [1:0] PE_OE_N_OUT,
   input wire logic SPI_ENABLE_IN,
   input wire logic SPI_MASTER_SELECT_IN,
   input wire logic [3:0] SPI_DRIVE_IN,
   input wire logic [1:0] TIMER_ONE_CHANNEL_ZERO_SEL_IN,
   input wire logic [1:0] TIMER_ONE_CHANNEL_ONE_SEL_IN,
   input wire logic [1:0] TIMER_TWO_CHANNEL_ZERO_SEL_IN,
   input wire logic [2:0] TIMER_DRIVE_IN,
   input wire logic SERIAL_IFACE_ENABLE_IN,
   input wire logic SERIAL_TX_DATA_IN
);
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!NRST_IN);
   ////////////////////////////////////////////////////////////////////
   // Peripheral ownership conditions
   sequence spi_slave_s;
      CE_IN && SPI_ENABLE_IN && !SPI_MASTER_SELECT_IN;
   endsequence
   sequence serial_on_s;
      CE_IN && SERIAL_IFACE_ENABLE_IN;
   endsequence
   ////////////////////////////////////////////////////////////////////
   // Pullups; a pad that drives must never also pull
   AST_PC_PULLUP: assert property (
      (PC_PULLUP_OUT & $past(PORT_C_DIRECTION_IN)) == 2'h0)
      else $error("port C pullup on an output");
   AST_PD_PULLUP: assert property (
      (PD_PULLUP_OUT & ~PD_OE_N_OUT) == 7'h00)
      else $error("port D pullup on a driven pad");
   // Every pad released straight after reset
   AST_RESET_IN: assert property (
      $rose(NRST_IN) |-> PD_OE_N_OUT == 7'h7F && PE_OE_N_OUT == 2'h3)
      else $error("pad driven after reset");
   // Peripheral owners decide drive, not direction bits
   AST_SPI_SS: assert property (
      spi_slave_s |=> PD_OE_N_OUT[0] == !$past(SPI_DRIVE_IN[0]))
      else $error("slave select drive wrong");
   AST_SPI_PINS: assert property (
      CE_IN && SPI_ENABLE_IN |=>
      PD_OE_N_OUT[3:1] == ~$past(SPI_DRIVE_IN[3:1]))
      else $error("SPI pad drive wrong");
   AST_TIMER_TWO: assert property (
      CE_IN && TIMER_TWO_CHANNEL_ZERO_SEL_IN != 2'h0 |=>
      PD_OE_N_OUT[6] == !$past(TIMER_DRIVE_IN[2]))
      else $error("timer two pad drive wrong");
   AST_TIMER_ONE: assert property (
      CE_IN && TIMER_ONE_CHANNEL_ZERO_SEL_IN != 2'h0 |=>
      PD_OE_N_OUT[4] == !$past(TIMER_DRIVE_IN[0]))
      else $error("timer one pad drive wrong");
   AST_TIMER_ONE_B: assert property (
      CE_IN && TIMER_ONE_CHANNEL_ONE_SEL_IN != 2'h0 |=>
      PD_OE_N_OUT[5] == !$past(TIMER_DRIVE_IN[1]))
      else $error("timer one channel one drive wrong");
   AST_SERIAL_TX: assert property (
      serial_on_s |=> !PE_OE_N_OUT[0] &&
      PE_PIN_OUT[0] == $past(SERIAL_TX_DATA_IN))
      else $error("transmit pad wrong");
   AST_SERIAL_RX: assert property (
      serial_on_s |=> PE_OE_N_OUT[1])
      else $error("receive pad driven");
endmodule

bind shared_pin_ports shared_pin_ports_monitor mon (
   .REF_CLK_IN, .NRST_IN, .CE_IN, .PORT_C_DIRECTION_IN, .PC_PULLUP_OUT,
   .PD_OE_N_OUT, .PD_PULLUP_OUT, .PE_PIN_OUT, .PE_OE_N_OUT,
   .SPI_ENABLE_IN, .SPI_MASTER_SELECT_IN, .SPI_DRIVE_IN,
   .TIMER_ONE_CHANNEL_ZERO_SEL_IN, .TIMER_ONE_CHANNEL_ONE_SEL_IN,
   .TIMER_TWO_CHANNEL_ZERO_SEL_IN,
   .TIMER_DRIVE_IN, .SERIAL_IFACE_ENABLE_IN, .SERIAL_TX_DATA_IN
);
`default_nettype wire

// >>> pad_world.sv
// Purpose: Pads and outside drivers of one port.
// Assumes: Outside drivers yield to the block's own drive.
// Notes: A floating pad without pullup toggles every cycle.
`timescale 1ns/1ps
`default_nettype none

module pad_world #(
   parameter W = 7
) (
   input wire logic clk_in,
   input wire logic [W-1:0] drv_in,
   input wire logic [W-1:0] oe_n_in,
   input wire logic [W-1:0] pullup_in,
   input wire logic [W-1:0] ext_val_in,
   input wire logic [W-1:0] ext_en_in,
   output logic [W-1:0] pad_out
);
   integer i;
   initial pad_out = '0;
   // Resolve each pad; floating pads without pullup never hold the old level
   always @(posedge clk_in) begin
      for (i = 0; i < W; i = i + 1) begin
         if (!oe_n_in[i])
            pad_out[i] <= drv_in[i];
         else if (ext_en_in[i])
            pad_out[i] <= ext_val_in[i];
         else if (pullup_in[i])
            pad_out[i] <= 1'h1;
         else
            pad_out[i] <= ~pad_out[i];
      end
   end
endmodule
`default_nettype wire

// >>> shared_pin_ports_test.sv
// Purpose: Self-checking bench of the shared-pin port block.
// Assumes: CE_IN high except in its own test.
// Notes: Fixed settle waits cover the pad synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "shared_ports_consts.vh"

module shared_pin_parallel_ports_test;
   logic clk = 1'h0, nrst = 1'h0, ce = 1'h1, wr = 1'h0, rd = 1'h0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic [1:0] pc_dir = 2'h0, t1c0 = 2'h0, t1c1 = 2'h0, t2c0 = 2'h0;
   logic spi_en = 1'h0, spi_mst = 1'h0, sci_en = 1'h0, sci_tx = 1'h1;
   logic [3:0] spi_dat = 4'h0, spi_drv = 4'h0;
   logic [2:0] t_dat = 3'h0, t_drv = 3'h0;
   logic [6:0] d_en = 7'h00;
   logic [1:0] e_en = 2'h0;
   wire [7:0] rdata;
   wire [1:0] pc_pu, pe_pad, pe_out, pe_oe_n;
   wire [6:0] pd_pad, pd_out, pd_oe_n, pd_pu;
   integer fail_count = 0, samples_checked = 0, i;
   // Table rows: address, write data, read-back
   logic [31:0] rows [0:7] = '{{`PC_PUE_ADDR, 8'hFF, 8'h03},
      {`PD_PUE_ADDR, 8'hFF, 8'h7F}, {`PD_PUE_ADDR, 8'h00, 8'h00},
      {`PD_DIR_ADDR, 8'hAA, 8'h2A}, {`PD_DIR_ADDR, 8'h00, 8'h00},
      {`PE_DIR_ADDR, 8'hFE, 8'h02}, {`PE_DIR_ADDR, 8'h00, 8'h00},
      {16'h0010, 8'h5A, 8'h00}};

   initial forever #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////
   shared_pin_ports uut (.REF_CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
      .RDATA_OUT(rdata), .PORT_C_DIRECTION_IN(pc_dir),
      .PC_PULLUP_OUT(pc_pu), .PD_PIN_IN(pd_pad), .PD_PIN_OUT(pd_out),
      .PD_OE_N_OUT(pd_oe_n), .PD_PULLUP_OUT(pd_pu), .PE_PIN_IN(pe_pad),
      .PE_PIN_OUT(pe_out), .PE_OE_N_OUT(pe_oe_n),
      .SPI_ENABLE_IN(spi_en), .SPI_MASTER_SELECT_IN(spi_mst),
      .SPI_DATA_IN(spi_dat), .SPI_DRIVE_IN(spi_drv),
      .TIMER_ONE_CHANNEL_ZERO_SEL_IN(t1c0),
      .TIMER_ONE_CHANNEL_ONE_SEL_IN(t1c1),
      .TIMER_TWO_CHANNEL_ZERO_SEL_IN(t2c0), .TIMER_DATA_IN(t_dat),
      .TIMER_DRIVE_IN(t_drv), .SERIAL_IFACE_ENABLE_IN(sci_en),
      .SERIAL_TX_DATA_IN(sci_tx));
   pad_world #(.W(7)) dpads (.clk_in(clk), .drv_in(pd_out),
      .oe_n_in(pd_oe_n), .pullup_in(pd_pu), .ext_val_in(7'h55),
      .ext_en_in(d_en), .pad_out(pd_pad));
   pad_world #(.W(2)) epads (.clk_in(clk), .drv_in(pe_out),
      .oe_n_in(pe_oe_n), .pullup_in(2'h0), .ext_val_in(2'h0),
      .ext_en_in(e_en), .pad_out(pe_pad));
   ////////////////////////////////////////////////////////////////////
   // Shared bus cycles and comparison
   task chk(input [7:0] got, input [7:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
         end
      end
   endtask
   task bus_wr(input [15:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'h1;
         @(posedge clk);
         wr <= 1'h0;
      end
   endtask
   task bus_rd(input [15:0] a, input [7:0] exp);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'h1;
         @(posedge clk);
         rd <= 1'h0;
         #1;
         chk(rdata, exp);
      end
   endtask
   // Long enough for the pad synchroniser to agree
   task settle;
      begin
         repeat (8) @(posedge clk);
         #1;
      end
   endtask
   task summarize;
      begin
         if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // Watchdog, far beyond the few hundred cycles needed
   initial begin
      #2000000;
      fail_count = fail_count + 1;
      summarize;
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      #1;
      chk({1'h0, pd_oe_n}, 8'h7F);
      chk({6'h00, pe_oe_n}, 8'h03);
      @(posedge clk);
      nrst <= 1'h1;
      for (i = 0; i < 8; i = i + 1) begin
         bus_wr(rows[i][31:16], rows[i][15:8]);
         bus_rd(rows[i][31:16], rows[i][7:0]);
      end
      @(posedge clk);
      pc_dir <= 2'h1;
      settle;
      chk({6'h00, pc_pu}, 8'h02);
      // Latch written first while pads are inputs
      d_en <= 7'h7F;
      bus_wr(`PD_DATA_ADDR, 8'h2A);
      settle;
      bus_rd(`PD_DATA_ADDR, 8'h55);
      bus_wr(`PD_DIR_ADDR, 8'h7F);
      settle;
      bus_rd(`PD_DATA_ADDR, 8'h2A);
      chk({1'h0, pd_out}, 8'h2A);
      chk({1'h0, pd_oe_n}, 8'h00);
      d_en <= 7'h00;
      bus_wr(`PD_PUE_ADDR, 8'h7F);
      bus_wr(`PD_DIR_ADDR, 8'h0F);
      settle;
      chk({1'h0, pd_pu}, 8'h70);
      bus_rd(`PD_DATA_ADDR, 8'h7A);
      // Reset in mid-run keeps the data latch
      @(posedge clk);
      nrst <= 1'h0;
      @(posedge clk);
      nrst <= 1'h1;
      bus_rd(`PD_DIR_ADDR, 8'h00);
      bus_wr(`PD_DIR_ADDR, 8'h0F);
      d_en <= 7'h70;
      spi_en <= 1'h1;
      spi_drv <= 4'h2;
      settle;
      chk({4'h0, pd_oe_n[3:0]}, 8'h0D);
      bus_rd(`PD_DATA_ADDR, 8'h5A);
      @(posedge clk);
      spi_mst <= 1'h1;
      settle;
      chk({4'h0, pd_oe_n[3:0]}, 8'h0C);
      @(posedge clk);
      spi_en <= 1'h0;
      settle;
      chk({4'h0, pd_oe_n[3:0]}, 8'h00);
      // Timer channels take pads 6..4
      d_en <= 7'h00;
      @(posedge clk);
      t2c0 <= 2'h1;
      t1c0 <= 2'h2;
      t_drv <= 3'h4;
      t_dat <= 3'h4;
      bus_wr(`PD_DIR_ADDR, 8'h1F);
      settle;
      chk({5'h00, pd_oe_n[6:4]}, 8'h03);
      chk({7'h00, pd_out[6]}, 8'h01);
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clk);
         t1c1 <= i[1:0];
         t_drv <= 3'h6;
         settle;
         chk({7'h00, pd_oe_n[5]}, {7'h00, i == 0});
      end
      // Serial interface owns both port E pads
      @(posedge clk);
      sci_en <= 1'h1;
      bus_wr(`PE_DATA_ADDR, 8'h03);
      bus_wr(`PE_DIR_ADDR, 8'h02);
      settle;
      chk({6'h00, pe_oe_n}, 8'h02);
      chk({7'h00, pe_out[0]}, 8'h01);
      bus_rd(`PE_DATA_ADDR, 8'h03);
      @(posedge clk);
      sci_en <= 1'h0;
      e_en <= 2'h1;
      settle;
      chk({6'h00, pe_oe_n}, 8'h01);
      bus_rd(`PE_DATA_ADDR, 8'h02);
      // Clock enable low: a write strobe must be ignored
      @(posedge clk);
      ce <= 1'h0;
      bus_wr(`PD_DIR_ADDR, 8'h00);
      ce <= 1'h1;
      bus_rd(`PD_DIR_ADDR, 8'h1F);
      summarize;
   end
endmodule
`default_nettype wire
